// ==== logic/apd_ctrl.sv ====
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/10ps
module apd_ctrl
  import apd_pkg::*;
#(
  parameter longint unsigned IDLE_CYCLES = IDLE_CYC
) (
  input wire logic CLK_SYS_IN,
  input wire logic ARST_N_IN,
  input wire logic [2:0] TX_DATA_IN,
  input wire logic [2:0] RX_LINE_IN,
  input wire logic [2:0] RX_LEVEL_OK_IN,
  input wire logic HOLD_AWAKE_IN,
  input wire logic MANUAL_SLEEP_N_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [31:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  output logic [2:0] TX_LINE_OUT,
  output logic [2:0] TX_LINE_OE_OUT,
  output logic [2:0] RX_DATA_OUT,
  output logic LEVEL_OK_OUT,
  output logic PUMP_EN_OUT,
  output logic POWER_READY_OUT,
  output logic IRQ_OUT
);
  typedef enum logic [2:0] {
    ST_DOWN = 3'b001,
    ST_WAKE = 3'b010,
    ST_ON = 3'b100
  } pwr_t;

  function automatic logic sel(input logic [31:0] a, input logic [31:0] b);
    sel = (a[7:0] == b[7:0]);
  endfunction

  apd_sync_if sif ();
  logic [5:0] data_s;
  logic [2:0] lvl_s;
  logic hold_s;
  logic sleep_n_s;
  assign sif.raw = {TX_DATA_IN, RX_LINE_IN, RX_LEVEL_OK_IN[1:0]};
  apd_sync u_sync (.clk_in(CLK_SYS_IN), .arst_n_in(ARST_N_IN), .port(sif));
  apd_sync_if sif2 ();
  assign sif2.raw = {5'h00, RX_LEVEL_OK_IN[2], HOLD_AWAKE_IN, MANUAL_SLEEP_N_IN};
  apd_sync u_sync2 (.clk_in(CLK_SYS_IN), .arst_n_in(ARST_N_IN), .port(sif2));
  assign data_s = sif.sync[7:2];
  assign lvl_s = {sif2.sync[2], sif.sync[1:0]};
  assign hold_s = sif2.sync[1];
  assign sleep_n_s = sif2.sync[0];

  logic [5:0] data_d_r;
  logic [5:0] data_d_nxt;
  logic hold_d_r;
  logic hold_d_nxt;
  logic activity;
  logic hold_fall;
  assign activity = |(data_s ^ data_d_r);
  assign hold_fall = hold_d_r & ~hold_s;

  // register-side overrides; sel bit picks pins or registers for force inputs
  logic [2:0] ctrl_r;
  logic [2:0] ctrl_nxt;
  logic hold_eff;
  logic sleep_n_eff;
  assign hold_eff = ctrl_r[CTRL_SEL_BIT] ? ctrl_r[CTRL_HOLD_BIT] : hold_s;
  assign sleep_n_eff = ctrl_r[CTRL_SEL_BIT] ? ctrl_r[CTRL_SLEEP_N_BIT] : sleep_n_s;

  // level monitor
  logic any_ok;
  logic loss_done;
  logic valid_done;
  logic level_r;
  logic level_nxt;
  assign any_ok = |lvl_s;
  apd_timer u_loss (
    .clk_in(CLK_SYS_IN), .arst_n_in(ARST_N_IN), .restart_in(any_ok),
    .limit_in(CNT_W'(LOSS_CYC)), .done_out(loss_done)
  );
  apd_timer u_valid (
    .clk_in(CLK_SYS_IN), .arst_n_in(ARST_N_IN), .restart_in(~any_ok),
    .limit_in(CNT_W'(VALID_CYC)), .done_out(valid_done)
  );
  // flag levels, independent of power state
  always_comb begin
    level_nxt = level_r;
    if (any_ok && valid_done) begin
      level_nxt = 1'b1;
    end else if (!any_ok && loss_done) begin
      level_nxt = 1'b0;
    end
  end

  // idle timer: restarted by activity or hold; expired on auto powerdown entry, not on manual sleep
  logic idle_done;
  logic idle_restart;
  logic auto_en;
  assign auto_en = ~hold_eff & sleep_n_eff;
  // hold keeps timer restarted, so 30 s run from the falling edge
  assign idle_restart = activity | hold_eff | hold_fall;
  // idle counter; it parks at expiry while down
  apd_timer u_idle (
    .clk_in(CLK_SYS_IN), .arst_n_in(ARST_N_IN), .restart_in(idle_restart),
    .limit_in(CNT_W'(IDLE_CYCLES)), .done_out(idle_done)
  );

  pwr_t st_r;
  pwr_t st_nxt;
  logic go_down;
  logic wake_done;
  logic [CNT_W-1:0] wake_cnt_r;
  logic [CNT_W-1:0] wake_cnt_nxt;
  // manual sleep wins; flag not used here
  assign go_down = ~sleep_n_eff | (auto_en & idle_done & ~activity);
  assign wake_done = (wake_cnt_r >= CNT_W'(WAKE_CYC));
  always_comb begin
    st_nxt = st_r;
    wake_cnt_nxt = '0;
    case (st_r)
      ST_DOWN: begin
        // wake needs sleep_n high plus hold or activity
        if (sleep_n_eff && (activity || hold_eff)) begin
          st_nxt = ST_WAKE;
        end
      end
      ST_WAKE: begin
        wake_cnt_nxt = wake_cnt_r + 1'b1;
        if (!sleep_n_eff) begin
          st_nxt = ST_DOWN;
        end else if (wake_done) begin
          st_nxt = ST_ON;
        end
      end
      ST_ON: begin
        if (go_down) begin
          st_nxt = ST_DOWN;
        end
      end
      default: st_nxt = ST_DOWN;
    endcase
  end

  // interrupts
  logic [2:0] irq_st_r;
  logic [2:0] irq_st_nxt;
  logic [2:0] irq_mask_r;
  logic [2:0] irq_mask_nxt;
  logic [2:0] ev;
  logic wr;
  logic rd_ok;
  logic [31:0] prdata_nxt;
  logic pready_nxt;
  logic pslverr_nxt;
  logic setup;
  assign ev[EV_DOWN_BIT] = (st_r != ST_DOWN) && (st_nxt == ST_DOWN);
  assign ev[EV_UP_BIT] = (st_r == ST_WAKE) && (st_nxt == ST_ON);
  assign ev[EV_LEVEL_BIT] = level_r ^ level_nxt;
  assign setup = PSEL_IN & ~PENABLE_IN;
  assign wr = PSEL_IN & PENABLE_IN & PREADY_OUT & PWRITE_IN;
  assign rd_ok = sel(PADDR_IN, ADDR_CTRL) | sel(PADDR_IN, ADDR_STAT)
    | sel(PADDR_IN, ADDR_IRQ_ST) | sel(PADDR_IN, ADDR_IRQ_MASK);

  // apb: no wait states; answer registered during setup
  always_comb begin
    ctrl_nxt = ctrl_r;
    irq_mask_nxt = irq_mask_r;
    irq_st_nxt = irq_st_r;
    if (wr && sel(PADDR_IN, ADDR_CTRL)) begin
      ctrl_nxt = PWDATA_IN[2:0];
    end
    if (wr && sel(PADDR_IN, ADDR_IRQ_MASK)) begin
      irq_mask_nxt = PWDATA_IN[2:0];
    end
    if (wr && sel(PADDR_IN, ADDR_IRQ_ST)) begin
      irq_st_nxt = irq_st_r & ~PWDATA_IN[2:0];
    end
    // a new event beats a same-cycle clear
    irq_st_nxt = irq_st_nxt | ev;
    pready_nxt = setup;
    pslverr_nxt = setup & ~rd_ok;
    prdata_nxt = 32'h0000_0000;
    if (setup && !PWRITE_IN) begin
      if (sel(PADDR_IN, ADDR_CTRL)) begin
        prdata_nxt = {29'h0, ctrl_r};
      end else if (sel(PADDR_IN, ADDR_STAT)) begin
        prdata_nxt = {26'h0, idle_done, st_r, level_r, lvl_s[0] | lvl_s[1] | lvl_s[2]};
      end else if (sel(PADDR_IN, ADDR_IRQ_ST)) begin
        prdata_nxt = {29'h0, irq_st_r};
      end else if (sel(PADDR_IN, ADDR_IRQ_MASK)) begin
        prdata_nxt = {29'h0, irq_mask_r};
      end
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      data_d_r <= 6'h00;
      hold_d_r <= 1'b0;
      level_r <= 1'b0;
      st_r <= ST_DOWN;
      wake_cnt_r <= '0;
      ctrl_r <= CTRL_RST;
      irq_st_r <= 3'h0;
      irq_mask_r <= IRQ_MASK_RST;
      PRDATA_OUT <= 32'h0000_0000;
      PREADY_OUT <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      TX_LINE_OUT <= 3'h0;
      TX_LINE_OE_OUT <= 3'h0;
      RX_DATA_OUT <= 3'h0;
      LEVEL_OK_OUT <= 1'b0;
      PUMP_EN_OUT <= 1'b0;
      POWER_READY_OUT <= 1'b0;
      IRQ_OUT <= 1'b0;
    end else begin
      data_d_r <= data_d_nxt;
      hold_d_r <= hold_d_nxt;
      level_r <= level_nxt;
      st_r <= st_nxt;
      wake_cnt_r <= wake_cnt_nxt;
      ctrl_r <= ctrl_nxt;
      irq_st_r <= irq_st_nxt;
      irq_mask_r <= irq_mask_nxt;
      PRDATA_OUT <= prdata_nxt;
      PREADY_OUT <= pready_nxt;
      PSLVERR_OUT <= pslverr_nxt;
      // transmit floats in powerdown, receivers always driven
      TX_LINE_OUT <= data_s[5:3];
      TX_LINE_OE_OUT <= {3{st_nxt == ST_ON}};
      RX_DATA_OUT <= data_s[2:0];
      LEVEL_OK_OUT <= level_nxt;
      PUMP_EN_OUT <= (st_nxt != ST_DOWN);
      POWER_READY_OUT <= (st_nxt == ST_ON);
      // a set mask bit hides its event from the interrupt line
      IRQ_OUT <= |(irq_st_nxt & ~irq_mask_nxt);
    end
  end
  assign data_d_nxt = data_s;
  assign hold_d_nxt = hold_s;

  // helper counter kept apart from the sequencer, so a stuck wake is caught
  logic [CNT_W-1:0] wake_age_r;
  logic [CNT_W-1:0] wake_age_nxt;
  always_comb begin
    wake_age_nxt = '0;
    if (st_r == ST_WAKE) begin
      wake_age_nxt = wake_age_r + 1'b1;
    end
  end
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      wake_age_r <= '0;
    end else begin
      wake_age_r <= wake_age_nxt;
    end
  end

  a_sleep_forces_down: assert property (@(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
    !sleep_n_eff |=> st_r == ST_DOWN) else $error("not down under manual sleep");
  a_auto_idle_down: assert property (@(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
    st_r == ST_ON && auto_en && idle_done && !activity |=> st_r == ST_DOWN)
    else $error("idle expiry ignored");
  a_hold_no_auto: assert property (@(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
    st_r == ST_ON && hold_eff && sleep_n_eff |=> st_r == ST_ON)
    else $error("auto powerdown while held");
  a_wake_on_edge: assert property (@(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
    st_r == ST_DOWN && activity && sleep_n_eff |=> st_r == ST_WAKE)
    else $error("activity did not wake");
  a_wake_time: assert property (@(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
    st_r == ST_WAKE |-> wake_age_r <= CNT_W'(WAKE_CYC))
    else $error("wake too slow");
  a_down_stays: assert property (@(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
    st_r == ST_DOWN && !activity && !hold_eff |=> st_r == ST_DOWN)
    else $error("woke with no cause");
  a_flag_rise: assert property (@(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
    (!level_r && any_ok) [*8] ##1 any_ok [*8] ##1 any_ok [*8] ##1 any_ok [*2] |=> level_r)
    else $error("flag not raised");
  a_flag_fall: assert property (@(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
    level_r && !any_ok |-> ##[1:760] (!level_r || any_ok))
    else $error("flag not lowered");
  a_tx_float: assert property (@(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
    st_r == ST_DOWN |-> TX_LINE_OE_OUT == 3'h0) else $error("tx driven in powerdown");
  a_rx_driven: assert property (@(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
    1'b1 |=> RX_DATA_OUT == $past(data_s[2:0])) else $error("receiver output stalled");
endmodule

// ==== logic/apd_pkg.sv ====
package apd_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned LOSS_TIME_NS = 30000;
  localparam int unsigned VALID_TIME_NS = 1000;
  localparam int unsigned IDLE_TIME_S = 30;
  localparam int unsigned WAKE_TIME_NS = 100000;
  localparam int unsigned LOSS_CYC = (LOSS_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned VALID_CYC = (VALID_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned WAKE_CYC = (WAKE_TIME_NS * (CLK_HZ / 1000000)) / 1000;
  localparam longint unsigned IDLE_CYC = longint'(IDLE_TIME_S) * longint'(CLK_HZ);
  localparam int CNT_W = 32;
  localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
  localparam logic [31:0] ADDR_STAT = 32'h0000_0004;
  localparam logic [31:0] ADDR_IRQ_ST = 32'h0000_0008;
  localparam logic [31:0] ADDR_IRQ_MASK = 32'h0000_000c;
  localparam int CTRL_HOLD_BIT = 0;
  localparam int CTRL_SLEEP_N_BIT = 1;
  localparam int CTRL_SEL_BIT = 2;
  localparam logic [2:0] CTRL_RST = 3'h2;
  localparam int EV_DOWN_BIT = 0;
  localparam int EV_UP_BIT = 1;
  localparam int EV_LEVEL_BIT = 2;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;
endpackage

// ==== logic/apd_sync_if.sv ====
`timescale 1ns/10ps
interface apd_sync_if;
  logic [7:0] raw;
  logic [7:0] sync;
  modport src (output raw, input sync);
  modport dst (input raw, output sync);
endinterface

// ==== logic/apd_sync.sv ====
`timescale 1ns/10ps
module apd_sync (
  input wire logic clk_in,
  input wire logic arst_n_in,
  apd_sync_if.dst port
);
  logic [7:0] meta_r;
  logic [7:0] hold_r;
  logic [7:0] meta_nxt;
  logic [7:0] hold_nxt;
  always_comb begin
    meta_nxt = port.raw;
    hold_nxt = meta_r;
  end
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta_r <= 8'h00;
      hold_r <= 8'h00;
    end else begin
      meta_r <= meta_nxt;
      hold_r <= hold_nxt;
    end
  end
  assign port.sync = hold_r;
endmodule

// ==== logic/apd_timer.sv ====
`timescale 1ns/10ps
module apd_timer
  import apd_pkg::*;
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic restart_in,
  input wire logic [CNT_W-1:0] limit_in,
  output logic done_out
);
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  // counts to the limit and parks there until restarted
  always_comb begin
    cnt_nxt = cnt_r;
    if (restart_in) begin
      cnt_nxt = '0;
    end else if (cnt_r < limit_in) begin
      cnt_nxt = cnt_r + 1'b1;
    end
  end
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
  assign done_out = (cnt_r >= limit_in);
endmodule

// ==== testbench/host_model.sv ====
`timescale 1ns/10ps
module host_model (
  input wire logic clk_in,
  input wire logic flag_in,
  input wire logic [1:0] route_in,
  input wire logic hold_in,
  input wire logic sleep_n_in,
  input wire logic [2:0] tx_in,
  output logic hold_out,
  output logic sleep_n_out,
  output logic [2:0] tx_out
);
  // pins are registered, so the block never sees a change at the sampling edge
  always_ff @(posedge clk_in) begin
    hold_out <= route_in[0] ? flag_in : hold_in;
    sleep_n_out <= route_in[1] ? flag_in : sleep_n_in;
    tx_out <= tx_in;
  end
endmodule

// ==== testbench/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
  import apd_pkg::*;
  localparam int IDL = 200;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic psel = 1'h0;
  logic pen = 1'h0;
  logic pwr = 1'h0;
  logic hold = 1'h0;
  logic sln = 1'h1;
  logic [1:0] route = 2'h0;
  logic [2:0] tx = 3'h0;
  logic [2:0] rx = 3'h0;
  logic [2:0] lok = 3'h0;
  logic [2:0] txl, txoe, rxd, txm;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rv;
  logic [31:0] seed = 32'h00018014;
  logic pready, pslverr, flag, pump, prdy, irq, ev, hw, sw;
  int errors = 0;
  int tests_run = 0;
  int c;

  host_model hm (.clk_in(clk), .flag_in(flag), .route_in(route), .hold_in(hold),
    .sleep_n_in(sln), .tx_in(tx), .hold_out(hw), .sleep_n_out(sw), .tx_out(txm));
  apd_ctrl #(.IDLE_CYCLES(IDL)) dut (.CLK_SYS_IN(clk), .ARST_N_IN(rst_n),
    .TX_DATA_IN(txm), .RX_LINE_IN(rx), .RX_LEVEL_OK_IN(lok), .HOLD_AWAKE_IN(hw),
    .MANUAL_SLEEP_N_IN(sw), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .TX_LINE_OUT(txl), .TX_LINE_OE_OUT(txoe), .RX_DATA_OUT(rxd),
    .LEVEL_OK_OUT(flag), .PUMP_EN_OUT(pump), .POWER_READY_OUT(prdy), .IRQ_OUT(irq));

  task automatic close_out();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask

  // bench view of power: pw 1 means transmitters up and pump on
  task automatic ckp(input int pw);
    chk({31'h0, prdy}, pw);
    chk({31'h0, pump}, pw);
    chk({29'h0, txoe}, pw ? 32'h7 : 32'h0);
  endtask

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    // values read right at the edge are the ones the slave saw there
    do begin
      @(posedge clk);
    end while (pready !== 1'h1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(rv & m, e);
  endtask

  function automatic logic sg(int s);
    return s == 0 ? prdy : (s == 1 ? flag : irq);
  endfunction

  task automatic waitv(input int s, input logic v, input int mx);
    c = 0;
    @(negedge clk);
    while (sg(s) !== v && c < mx) begin
      @(negedge clk);
      c++;
    end
  endtask

  task automatic win(input int lo, input int hi);
    chk({31'h0, c >= lo && c <= hi}, 32'h1);
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic poke();
    seed = lfsr(seed);
    @(posedge clk);
    tx <= tx ^ (seed[2:0] | 3'h1);
    rx <= seed[5:3];
  endtask

  initial begin
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    close_out();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    rd(ADDR_CTRL, 32'h7, {29'h0, CTRL_RST});
    rd(ADDR_IRQ_MASK, 32'h7, {29'h0, IRQ_MASK_RST});
    rd(ADDR_STAT, 32'h1c, 32'h4);
    ckp(0);
    apb(1'h0, 32'h10, 32'h0);
    chk({31'h0, ev}, 32'h1);
    $display("test reset done");
    @(posedge clk);
    hold <= 1'h1;
    waitv(0, 1'h1, 3000);
    win(WAKE_CYC, WAKE_CYC + 12);
    ckp(1);
    for (int i = 0; i < 8; i++) begin
      poke();
    end
    repeat (6) @(negedge clk);
    chk({29'h0, txl}, {29'h0, tx});
    chk({29'h0, rxd}, {29'h0, rx});
    hold <= 1'h0;
    waitv(0, 1'h0, IDL + 60);
    win(IDL, IDL + 20);
    ckp(0);
    chk({29'h0, rxd}, {29'h0, rx});
    repeat (100) @(negedge clk);
    ckp(0);
    poke();
    waitv(0, 1'h1, 3000);
    win(WAKE_CYC, WAKE_CYC + 12);
    $display("test auto done");
    @(posedge clk);
    sln <= 1'h0;
    hold <= 1'h1;
    waitv(0, 1'h0, 20);
    ckp(0);
    repeat (100) @(negedge clk);
    ckp(0);
    sln <= 1'h1;
    waitv(0, 1'h1, 3000);
    ckp(1);
    @(posedge clk);
    lok <= 3'h2;
    waitv(1, 1'h1, 60);
    win(VALID_CYC - 2, VALID_CYC + 6);
    ckp(1);
    @(posedge clk);
    lok <= 3'h0;
    waitv(1, 1'h0, 900);
    win(LOSS_CYC - 2, LOSS_CYC + 8);
    ckp(1);
    @(posedge clk);
    sln <= 1'h0;
    lok <= 3'h4;
    waitv(1, 1'h1, 60);
    chk({31'h0, flag}, 32'h1);
    ckp(0);
    sln <= 1'h1;
    route <= 2'h3;
    waitv(0, 1'h1, 3000);
    ckp(1);
    $display("test flag done");
    @(posedge clk);
    lok <= 3'h0;
    waitv(0, 1'h0, 900);
    ckp(0);
    @(posedge clk);
    lok <= 3'h1;
    waitv(0, 1'h1, 3000);
    ckp(1);
    @(posedge clk);
    hold <= 1'h0;
    route <= 2'h2;
    lok <= 3'h0;
    waitv(0, 1'h0, 900);
    @(posedge clk);
    lok <= 3'h1;
    repeat (100) @(negedge clk);
    ckp(0);
    poke();
    waitv(0, 1'h1, 3000);
    ckp(1);
    route <= 2'h0;
    hold <= 1'h1;
    $display("test route done");
    rd(ADDR_IRQ_ST, 32'h7, 32'h7);
    chk({31'h0, irq}, 32'h1);
    apb(1'h1, ADDR_IRQ_MASK, 32'h7);
    waitv(2, 1'h0, 5);
    chk({31'h0, irq}, 32'h0);
    apb(1'h1, ADDR_IRQ_MASK, 32'h0);
    waitv(2, 1'h1, 5);
    chk({31'h0, irq}, 32'h1);
    apb(1'h1, ADDR_IRQ_ST, 32'h7);
    rd(ADDR_IRQ_ST, 32'h7, 32'h0);
    chk({31'h0, irq}, 32'h0);
    apb(1'h1, ADDR_CTRL, 32'h4);
    rd(ADDR_CTRL, 32'h7, 32'h4);
    waitv(0, 1'h0, 20);
    ckp(0);
    chk({31'h0, irq}, 32'h1);
    apb(1'h1, ADDR_CTRL, {29'h0, CTRL_RST});
    $display("test irq done");
    close_out();
  end
endmodule
